// ===== hdl/motor_drive_command_decode.sv
// command decode, dc pwm and stepping position logic for the motor driver
// How it works
// - two independent dc channel words
// - d0 low stops, high runs
// - d1 selects forward or reverse current
// - stopped: d2 picks hi-z or brake
// - duty code n gives n over 32
// - pwm period is 32 clock counts
// - zero duty code means full duty
// - level code clamped to 100..500 mv
// - d5 sets second phase lag or lead
// - hold-stop advances to marker low, holds
// - pulse count kept during hold-stop
// - hold-stop at marker low: no pulses
// - d7 low forces stepping outputs hi-z
// - position kept while outputs disabled
// - d8, d9 select drive mode
// - reset mode is micro step
// - zero-count switch: jump or hold by d10
// - first pulse after switch goes next quadrant
// - one-phase rest counts as cw quadrant
// - d10 picks full duty or equal-phase level
// - marker pulses at one-phase positions
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/100ps
module motor_drive_command_decode
#(
   parameter int PWM_PERIOD = motor_drive_pkg::PWM_COUNTS
)(
   // clock and reset
   input  wire logic        sys_clk_in,
   input  wire logic        reset_in,
   // axi4-lite write address
   input  wire logic [7:0]  s_axi_awaddr_in,
   input  wire logic        s_axi_awvalid_in,
   output logic             s_axi_awready_out,
   // axi4-lite write data
   input  wire logic [31:0] s_axi_wdata_in,
   input  wire logic [3:0]  s_axi_wstrb_in,
   input  wire logic        s_axi_wvalid_in,
   output logic             s_axi_wready_out,
   // axi4-lite write response
   output logic [1:0]       s_axi_bresp_out,
   output logic             s_axi_bvalid_out,
   input  wire logic        s_axi_bready_in,
   // axi4-lite read address
   input  wire logic [7:0]  s_axi_araddr_in,
   input  wire logic        s_axi_arvalid_in,
   output logic             s_axi_arready_out,
   // axi4-lite read data
   output logic [31:0]      s_axi_rdata_out,
   output logic [1:0]       s_axi_rresp_out,
   output logic             s_axi_rvalid_out,
   input  wire logic        s_axi_rready_in,
   // dc channel five power stage
   output logic             dc5_a_high_out,
   output logic             dc5_b_high_out,
   output logic             dc5_enable_out,
   // dc channel six power stage
   output logic             dc6_a_high_out,
   output logic             dc6_b_high_out,
   output logic             dc6_enable_out,
   // stepping drive
   output logic [5:0]       step_position_out,
   output logic             step_enable_out,
   output logic             step_full_duty_out,
   output logic [4:0]       peak_reference_level_out,
   output logic             position_marker_first_out,
   output logic             position_marker_second_out
);
   import motor_drive_pkg::*;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [4:0] clamp_level(input logic [4:0] code);
      clamp_level = (code < LEVEL_MIN_CODE) ? LEVEL_MIN_CODE :
                    (code > LEVEL_MAX_CODE) ? LEVEL_MAX_CODE : code;
   endfunction : clamp_level

   // pwm high while counter below duty; code zero is full duty
   function automatic logic pwm_on(input logic [4:0] duty, input logic [4:0] cnt);
      pwm_on = (duty == 5'h00) || (cnt < duty);
   endfunction : pwm_on

   // stopped stage: brake turns both high sides on, otherwise hi-z
   function automatic logic [2:0] stage_of(input logic [11:0] w, input logic [4:0] cnt);
      logic on;
      on = pwm_on(w[DC_DUTY_LSB +: DUTY_BITS], cnt);
      if (w[DC_RUN_BIT])
         stage_of = {on && !w[DC_DIR_BIT], on && w[DC_DIR_BIT], 1'b1};
      else
         stage_of = {3{w[DC_BRAKE_BIT]}};
   endfunction : stage_of

   function automatic logic [1:0] axi_resp_of(input logic [7:0] a, input logic wr);
      axi_resp_of = ((a == OFS_DC_FIVE) || (a == OFS_DC_SIX) || (a == OFS_STEP_SETUP) ||
                     (a == OFS_STEP_CTRL) || (wr ? (a == OFS_CMD) : (a == OFS_STATUS))) ?
                    2'h0 : 2'h2;
   endfunction : axi_resp_of

   // ----------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------
   logic [11:0]  dc_five;
   logic [11:0]  dc_six;
   logic [11:0]  setup;
   logic [15:0]  pulse_count;
   logic         step_pulse;
   logic [5:0]   position;
   logic [4:0]   pwm_cnt;
   logic         prev_micro;
   logic         switch_pending;
   logic         held;
   logic [7:0]   aw_addr;
   logic         aw_full;
   logic [31:0]  w_data;
   logic [3:0]   w_strb;
   logic         w_full;

   // ----------------------------------------------------------------
   // axi write path: address and data taken in either order
   // ----------------------------------------------------------------
   logic         wr_fire;
   logic [11:0]  cmd_payload;
   logic [3:0]   cmd_target;
   logic         cmd_write;

   assign s_axi_awready_out = !aw_full && !s_axi_bvalid_out;
   assign s_axi_wready_out  = !w_full && !s_axi_bvalid_out;
   assign wr_fire           = aw_full && w_full && !s_axi_bvalid_out;

   always_ff @(posedge sys_clk_in)
   begin
      if (reset_in)
      begin
         aw_full <= 1'b0;
         aw_addr <= 8'h00;
      end
      else if (s_axi_awvalid_in && s_axi_awready_out)
      begin
         aw_full <= 1'b1;
         aw_addr <= s_axi_awaddr_in;
      end
      else if (wr_fire)
         aw_full <= 1'b0;
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (reset_in)
      begin
         w_full <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end
      else if (s_axi_wvalid_in && s_axi_wready_out)
      begin
         w_full <= 1'b1;
         w_data <= s_axi_wdata_in;
         w_strb <= s_axi_wstrb_in;
      end
      else if (wr_fire)
         w_full <= 1'b0;
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (reset_in)
      begin
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out  <= 2'h0;
      end
      else if (wr_fire)
      begin
         s_axi_bvalid_out <= 1'b1;
         s_axi_bresp_out  <= axi_resp_of(aw_addr, 1'b1);
      end
      else if (s_axi_bready_in)
         s_axi_bvalid_out <= 1'b0;
   end

   // command port carries the 16-bit word; direct offsets map onto same targets
   always_comb
   begin
      cmd_write   = wr_fire && (w_strb[1:0] == 2'h3);
      cmd_payload = w_data[11:0];
      cmd_target  = 4'h0;
      unique case (aw_addr)
         OFS_CMD:        cmd_target = w_data[CMD_WIDTH-1:CMD_ADDR_LSB];
         OFS_DC_FIVE:    cmd_target = ADDR_DC_FIVE;
         OFS_DC_SIX:     cmd_target = ADDR_DC_SIX;
         OFS_STEP_SETUP: cmd_target = ADDR_STEP_SETUP;
         default:        cmd_target = 4'h0;
      endcase
   end

   // ----------------------------------------------------------------
   // write targets
   // ----------------------------------------------------------------
   // writes arriving while held at the marker are the host's fault; stored anyway
   always_ff @(posedge sys_clk_in)
   begin
      if (reset_in)
      begin
         dc_five <= DC_RESET;
         dc_six  <= DC_RESET;
         setup   <= SETUP_RESET;
      end
      else if (cmd_write)
      begin
         if (cmd_target == ADDR_DC_FIVE)
            dc_five <= cmd_payload;
         if (cmd_target == ADDR_DC_SIX)
            dc_six <= cmd_payload;
         if (cmd_target == ADDR_STEP_SETUP)
            setup <= cmd_payload;
      end
   end

   // ----------------------------------------------------------------
   // pulse count and step requests from the control register
   // ----------------------------------------------------------------
   logic step_allowed;
   logic hold_mode;
   logic micro;
   drive_mode_t mode;

   assign hold_mode = setup[ST_HOLD_BIT];
   assign micro     = !setup[ST_MODE0_BIT];
   assign mode      = micro ? MODE_MICRO :
                      (setup[ST_MODE1_BIT] ? MODE_ONE_TWO : MODE_TWO);

   // hold-stop reaching the marker, or set with marker already low, blocks pulses
   assign step_allowed = setup[ST_OE_BIT] && !(hold_mode && (held || position == 6'h00));

   always_ff @(posedge sys_clk_in)
   begin
      if (reset_in)
         pulse_count <= 16'h0000;
      else if (wr_fire && aw_addr == OFS_STEP_CTRL && w_strb[1:0] == 2'h3)
         pulse_count <= w_data[15:0];
      else if (step_pulse && !hold_mode && pulse_count != 16'h0000)
         pulse_count <= pulse_count - 16'h0001;
   end

   // in hold-stop the motor runs regardless of the count
   assign step_pulse = step_allowed && (hold_mode || pulse_count != 16'h0000);

   // ----------------------------------------------------------------
   // excitation position
   // ----------------------------------------------------------------
   logic [5:0] next_position;
   logic [1:0] quad;
   logic [5:0] step_size;

   // positions count up clockwise, so a one-phase rest already sits in its cw quadrant
   assign quad          = position[5:4];
   assign step_size     = (mode == MODE_TWO) ? 6'h10 :
                          (mode == MODE_ONE_TWO) ? 6'h08 : 6'h01;

   always_comb
   begin
      next_position = position;
      if (switch_pending && setup[ST_OE_BIT])
      begin
         if (step_pulse)
            next_position = setup[ST_CCW_BIT] ?
               {quad - 2'h1, 4'h8} : {quad + 2'h1, 4'h8};
         else if (!setup[ST_CC_BIT])
            next_position = {quad, 4'h8};
      end
      else if (step_pulse)
      begin
         if (setup[ST_CCW_BIT])
            next_position = position - step_size;
         else
            next_position = position + step_size;
      end
   end

   // position advances only while enabled, so it is kept across disable
   always_ff @(posedge sys_clk_in)
   begin
      if (reset_in)
         position <= 6'h00;
      else if (setup[ST_OE_BIT])
         position <= next_position;
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (reset_in)
      begin
         prev_micro     <= 1'b1;
         switch_pending <= 1'b0;
      end
      else
      begin
         prev_micro <= micro;
         if (prev_micro && !micro)
            switch_pending <= 1'b1;
         else if (micro || (setup[ST_OE_BIT] && (step_pulse || !setup[ST_CC_BIT])))
            switch_pending <= 1'b0;
      end
   end

   // latched once marker reached; cleared when hold-stop is released
   always_ff @(posedge sys_clk_in)
   begin
      if (reset_in)
         held <= 1'b0;
      else if (!hold_mode)
         held <= 1'b0;
      else if (position == 6'h00)
         held <= 1'b1;
   end

   // ----------------------------------------------------------------
   // dc pwm and stepping outputs
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_in)
   begin
      if (reset_in || pwm_cnt == 5'(PWM_PERIOD - 1))
         pwm_cnt <= 5'h00;
      else
         pwm_cnt <= pwm_cnt + 5'h01;
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (reset_in)
      begin
         {dc5_a_high_out, dc5_b_high_out, dc5_enable_out} <= 3'h0;
         {dc6_a_high_out, dc6_b_high_out, dc6_enable_out} <= 3'h0;
      end
      else
      begin
         {dc5_a_high_out, dc5_b_high_out, dc5_enable_out} <= stage_of(dc_five, pwm_cnt);
         {dc6_a_high_out, dc6_b_high_out, dc6_enable_out} <= stage_of(dc_six, pwm_cnt);
      end
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (reset_in)
      begin
         step_position_out          <= 6'h00;
         step_enable_out            <= 1'b0;
         step_full_duty_out         <= 1'b0;
         peak_reference_level_out   <= LEVEL_MIN_CODE;
         position_marker_first_out  <= 1'b0;
         position_marker_second_out <= 1'b0;
      end
      else
      begin
         step_position_out        <= next_position;
         step_enable_out          <= setup[ST_OE_BIT];
         step_full_duty_out       <= !micro && !setup[ST_CC_BIT];
         peak_reference_level_out <= clamp_level(setup[4:0]);
         position_marker_first_out  <= next_position == 6'h00;
         position_marker_second_out <= next_position == 6'h10;
      end
   end

   // ----------------------------------------------------------------
   // axi read path
   // ----------------------------------------------------------------
   assign s_axi_arready_out = !s_axi_rvalid_out;

   always_ff @(posedge sys_clk_in)
   begin
      if (reset_in)
      begin
         s_axi_rvalid_out <= 1'b0;
         s_axi_rdata_out  <= 32'h0000_0000;
         s_axi_rresp_out  <= 2'h0;
      end
      else if (s_axi_arvalid_in && s_axi_arready_out)
      begin
         s_axi_rvalid_out <= 1'b1;
         s_axi_rresp_out  <= axi_resp_of(s_axi_araddr_in, 1'b0);
         unique case (s_axi_araddr_in)
            OFS_DC_FIVE:    s_axi_rdata_out <= {20'h00000, dc_five};
            OFS_DC_SIX:     s_axi_rdata_out <= {20'h00000, dc_six};
            OFS_STEP_SETUP: s_axi_rdata_out <= {20'h00000, setup};
            OFS_STEP_CTRL:  s_axi_rdata_out <= {16'h0000, pulse_count};
            OFS_STATUS:     s_axi_rdata_out <= {20'h00000, held, switch_pending,
                                                mode, position_marker_first_out,
                                                step_enable_out, position};
            default:        s_axi_rdata_out <= 32'h0000_0000;
         endcase
      end
      else if (s_axi_rready_in)
         s_axi_rvalid_out <= 1'b0;
   end
endmodule : motor_drive_command_decode

// ===== hdl/motor_drive_pkg.sv
// constants shared by the motor drive command decoder
package motor_drive_pkg;
   // ----------------------------------------------------------------
   // command word layout
   // ----------------------------------------------------------------
   localparam int                CMD_WIDTH        = 16;
   localparam int                CMD_ADDR_LSB     = 12;
   localparam logic [3:0]        ADDR_DC_FIVE     = 4'h5;
   localparam logic [3:0]        ADDR_DC_SIX      = 4'h6;
   localparam logic [3:0]        ADDR_STEP_SETUP  = 4'h8;
   // ----------------------------------------------------------------
   // axi register byte offsets (index times four)
   // ----------------------------------------------------------------
   localparam logic [7:0]        OFS_CMD          = 8'h00;
   localparam logic [7:0]        OFS_DC_FIVE      = 8'h14;
   localparam logic [7:0]        OFS_DC_SIX       = 8'h18;
   localparam logic [7:0]        OFS_STEP_SETUP   = 8'h20;
   localparam logic [7:0]        OFS_STEP_CTRL    = 8'h40;
   localparam logic [7:0]        OFS_STATUS       = 8'h44;
   // ----------------------------------------------------------------
   // dc word fields
   // ----------------------------------------------------------------
   localparam int                DC_RUN_BIT       = 0;
   localparam int                DC_DIR_BIT       = 1;
   localparam int                DC_BRAKE_BIT     = 2;
   localparam int                DC_DUTY_LSB      = 3;
   localparam int                DUTY_BITS        = 5;
   // ----------------------------------------------------------------
   // stepping setup fields
   // ----------------------------------------------------------------
   localparam int                ST_LEVEL_LSB     = 0;
   localparam int                ST_CCW_BIT       = 5;
   localparam int                ST_HOLD_BIT      = 6;
   localparam int                ST_OE_BIT        = 7;
   localparam int                ST_MODE0_BIT     = 8;
   localparam int                ST_MODE1_BIT     = 9;
   localparam int                ST_CC_BIT        = 10;
   localparam logic [4:0]        LEVEL_MIN_CODE   = 5'h05;
   localparam logic [4:0]        LEVEL_MAX_CODE   = 5'h19;
   localparam logic [11:0]       SETUP_RESET      = 12'h000;
   localparam logic [11:0]       DC_RESET         = 12'h000;
   localparam int                LEVEL_UNIT_MV    = 20;
   // ----------------------------------------------------------------
   // excitation position: 64 micro steps per electrical cycle
   // ----------------------------------------------------------------
   localparam int                POS_BITS         = 6;
   localparam int                QUAD_STEPS       = 16;
   localparam int                FULL_DUTY        = 32;
   localparam int                CLK_MHZ          = 40;
   localparam int                PWM_COUNTS       = 32;

   typedef enum logic [1:0] {
      MODE_MICRO,
      MODE_TWO,
      MODE_ONE_TWO
   } drive_mode_t;
endpackage : motor_drive_pkg

// ===== sim/dc_coil_model.sv
// behavioural coil load that measures what one dc power stage drives
`timescale 1ns/100ps
module dc_coil_model #(
   parameter int PERIOD = 32
)(
   // stage drive
   input  wire logic       clk_in,
   input  wire logic       a_high_in,
   input  wire logic       b_high_in,
   input  wire logic       enable_in,
   // measured cycles per window
   output logic [6:0]      fwd_out,
   output logic [6:0]      rev_out,
   output logic [6:0]      brake_out
);
   int         n = 0;
   logic [6:0] f = 7'h00;
   logic [6:0] r = 7'h00;
   logic [6:0] b = 7'h00;
   // window of one period: any phase of it sees exactly the duty count
   always @(posedge clk_in)
   begin
      if (enable_in && a_high_in && !b_high_in) f = f + 7'h01;
      if (enable_in && b_high_in && !a_high_in) r = r + 7'h01;
      if (enable_in && a_high_in && b_high_in) b = b + 7'h01;
      n = n + 1;
      if (n == PERIOD)
      begin
         fwd_out <= f;
         rev_out <= r;
         brake_out <= b;
         {f, r, b} = 21'h0;
         n = 0;
      end
   end
endmodule : dc_coil_model

// ===== sim/motor_drive_chk.sv
// port-level assertions for the motor drive command decoder
`timescale 1ns/100ps
module motor_drive_chk
   import motor_drive_pkg::*;
#(
   parameter int PWM_PERIOD = 32
)(
   // clock and reset
   input  wire logic        sys_clk_in,
   input  wire logic        reset_in,
   // register bus
   input  wire logic        s_axi_awvalid_in,
   input  wire logic        s_axi_awready_out,
   input  wire logic        s_axi_wvalid_in,
   input  wire logic        s_axi_wready_out,
   input  wire logic [1:0]  s_axi_bresp_out,
   input  wire logic        s_axi_bvalid_out,
   input  wire logic        s_axi_bready_in,
   input  wire logic        s_axi_arvalid_in,
   input  wire logic        s_axi_arready_out,
   input  wire logic [31:0] s_axi_rdata_out,
   input  wire logic        s_axi_rvalid_out,
   input  wire logic        s_axi_rready_in,
   // stepping drive
   input  wire logic [5:0]  step_position_out,
   input  wire logic        step_enable_out,
   input  wire logic [4:0]  peak_reference_level_out,
   input  wire logic        position_marker_first_out,
   input  wire logic        position_marker_second_out
);
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (reset_in);

   chk_write_answer: assert property (
      s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
      |-> ##2 s_axi_bvalid_out) else $error("write not answered two cycles later");
   chk_resp_holds: assert property (
      s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
      else $error("write response dropped before bready");
   chk_write_busy: assert property (
      s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
      else $error("write accepted while response pending");
   chk_read_answer: assert property (
      s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
      else $error("read not answered one cycle later");
   chk_rdata_holds: assert property (
      s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
      else $error("read data changed before rready");
   chk_level_clamp: assert property (
      peak_reference_level_out >= LEVEL_MIN_CODE && peak_reference_level_out <= LEVEL_MAX_CODE)
      else $error("peak level outside clamp range");
   chk_marker_place: assert property (
      (!position_marker_first_out || step_position_out == 6'h00) &&
      (!position_marker_second_out || step_position_out == 6'h10))
      else $error("marker away from one-phase position");
   chk_idle_position: assert property (
      !step_enable_out |-> $stable(step_position_out))
      else $error("position moved while outputs disabled");

   cov_write_error: cover property (s_axi_bvalid_out && s_axi_bresp_out == 2'b10);
   cov_read_done: cover property (s_axi_rvalid_out && s_axi_rready_in);
   cov_marker_hit: cover property ($rose(position_marker_first_out));
endmodule : motor_drive_chk

bind motor_drive_command_decode motor_drive_chk #(.PWM_PERIOD(PWM_PERIOD)) u_chk (.*);

// ===== sim/motor_drive_command_decode_tb_top.sv
// self-checking bench for the motor drive command decoder
`timescale 1ns/100ps
module motor_drive_command_decode_tb_top;
   import motor_drive_pkg::*;
   localparam int PER = 32;
   logic        sys_clk_in, reset_in, s_axi_awvalid_in, s_axi_awready_out;
   logic [7:0]  s_axi_awaddr_in, s_axi_araddr_in;
   logic [31:0] s_axi_wdata_in, s_axi_rdata_out, rd;
   logic [3:0]  s_axi_wstrb_in;
   logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, rs;
   logic        s_axi_wvalid_in, s_axi_wready_out, s_axi_bvalid_out, s_axi_bready_in;
   logic        s_axi_arvalid_in, s_axi_arready_out, s_axi_rvalid_out, s_axi_rready_in;
   logic        dc5_a_high_out, dc5_b_high_out, dc5_enable_out;
   logic        dc6_a_high_out, dc6_b_high_out, dc6_enable_out;
   logic [5:0]  step_position_out;
   logic        step_enable_out, step_full_duty_out;
   logic [4:0]  peak_reference_level_out;
   logic        position_marker_first_out, position_marker_second_out;
   logic [6:0]  f5, r5, b5, f6, r6, b6;
   logic [7:0]  dcw [6] = '{8'h81, 8'h01, 8'h0B, 8'hFB, 8'h04, 8'h00};
   logic [4:0]  lv [5] = '{5'h00, 5'h05, 5'h06, 5'h19, 5'h1F};
   logic [2:0]  md [5] = '{3'b001, 3'b011, 3'b101, 3'b010, 3'b000};
   int          n_mismatch, n_tests, i;

   motor_drive_command_decode #(.PWM_PERIOD(PER)) dut (.*);
   dc_coil_model #(.PERIOD(PER)) coil5 (.clk_in(sys_clk_in), .a_high_in(dc5_a_high_out),
      .b_high_in(dc5_b_high_out), .enable_in(dc5_enable_out), .fwd_out(f5), .rev_out(r5),
      .brake_out(b5));
   dc_coil_model #(.PERIOD(PER)) coil6 (.clk_in(sys_clk_in), .a_high_in(dc6_a_high_out),
      .b_high_in(dc6_b_high_out), .enable_in(dc6_enable_out), .fwd_out(f6), .rev_out(r6),
      .brake_out(b6));

   initial
   begin
      sys_clk_in = 1'b0;
      forever #12.5 sys_clk_in = ~sys_clk_in;
   end
   // ----------------------------------------------------------------
   // bus tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %0t ns: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge sys_clk_in);
      s_axi_awaddr_in <= a;
      s_axi_wdata_in <= d;
      s_axi_awvalid_in <= 1'b1;
      s_axi_wvalid_in <= 1'b1;
      s_axi_bready_in <= 1'b1;
      do
      begin
         @(posedge sys_clk_in);
         if (s_axi_awvalid_in && s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
         if (s_axi_wvalid_in && s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
      end while (!s_axi_bvalid_out);
      s_axi_bready_in <= 1'b0;
      check(s_axi_bresp_out, er);
   endtask : wr

   task automatic rdr(input logic [7:0] a);
      @(posedge sys_clk_in);
      s_axi_araddr_in <= a;
      s_axi_arvalid_in <= 1'b1;
      s_axi_rready_in <= 1'b1;
      do
      begin
         @(posedge sys_clk_in);
         if (s_axi_arvalid_in && s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
      end while (!s_axi_rvalid_out);
      s_axi_rready_in <= 1'b0;
      rd = s_axi_rdata_out;
      rs = s_axi_rresp_out;
   endtask : rdr

   task automatic dc_chk(input logic [7:0] w, input logic [6:0] f, r, b);
      logic [6:0] d;
      d = (w[7:3] == 5'h00) ? 7'(PER) : {2'b00, w[7:3]};
      check(f, (w[1:0] == 2'b01) ? d : 7'h00);
      check(r, (w[1:0] == 2'b11) ? d : 7'h00);
      if (!w[0]) check(b, w[2] ? 7'(PER) : 7'h00);
   endtask : dc_chk

   task automatic close_out;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : close_out

   initial
   begin
      #(25 * 20000);
      n_mismatch++;
      close_out();
   end
   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial
   begin
      {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = '0;
      {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = '0;
      {s_axi_arvalid_in, s_axi_rready_in} = '0;
      s_axi_wstrb_in = 4'hF;
      reset_in = 1'b1;
      n_mismatch = 0;
      n_tests = 0;
      repeat (5) @(posedge sys_clk_in);
      reset_in <= 1'b0;
      rdr(OFS_STATUS);
      check(rd[9:8], MODE_MICRO);
      check(peak_reference_level_out, LEVEL_MIN_CODE);
      wr(8'h30, 32'h1, 2'b10);
      rdr(8'h30);
      check(rs, 2'b10);
      check(rd, 32'h0);
      // both channels at once, opposite table ends, so crosstalk shows
      for (i = 0; i < 6; i++)
      begin
         wr(OFS_CMD, {16'h0, ADDR_DC_FIVE, 4'h0, dcw[i]}, 2'b00);
         wr(OFS_DC_SIX, {24'h0, dcw[5 - i]}, 2'b00);
         repeat (3 * PER) @(posedge sys_clk_in);
         dc_chk(dcw[i], f5, r5, b5);
         dc_chk(dcw[5 - i], f6, r6, b6);
      end
      for (i = 0; i < 5; i++)
      begin
         wr(OFS_STEP_SETUP, {27'h0, lv[i]}, 2'b00);
         rdr(OFS_STEP_SETUP);
         check(rd[11:0], {7'h0, lv[i]});
         check(peak_reference_level_out, (lv[i] < LEVEL_MIN_CODE) ? LEVEL_MIN_CODE :
               (lv[i] > LEVEL_MAX_CODE) ? LEVEL_MAX_CODE : lv[i]);
      end
      for (i = 0; i < 5; i++)
      begin
         wr(OFS_STEP_SETUP, {21'h0, md[i], 8'h00}, 2'b00);
         rdr(OFS_STATUS);
         check(rd[9:8], !md[i][0] ? MODE_MICRO : md[i][1] ? MODE_ONE_TWO : MODE_TWO);
         check(step_full_duty_out, md[i][0] && !md[i][2]);
      end
      wr(OFS_STEP_SETUP, 32'h80, 2'b00);
      wr(OFS_STEP_CTRL, 32'd5, 2'b00);
      repeat (20) @(posedge sys_clk_in);
      check(step_enable_out, 1'b1);
      rdr(OFS_STATUS);
      check(rd[5:0], 6'h05);
      wr(OFS_STEP_SETUP, 32'hA0, 2'b00);
      wr(OFS_STEP_CTRL, 32'd5, 2'b00);
      repeat (20) @(posedge sys_clk_in);
      check(step_position_out, 6'h00);
      wr(OFS_STEP_SETUP, 32'h00, 2'b00);
      wr(OFS_STEP_CTRL, 32'd3, 2'b00);
      repeat (20) @(posedge sys_clk_in);
      check(step_enable_out, 1'b0);
      check(step_position_out, 6'h00);
      wr(OFS_STEP_SETUP, 32'h80, 2'b00);
      repeat (20) @(posedge sys_clk_in);
      check(step_position_out, 6'h03);
      wr(OFS_STEP_SETUP, 32'h00, 2'b00);
      wr(OFS_STEP_CTRL, 32'd7, 2'b00);
      wr(OFS_STEP_SETUP, 32'hC0, 2'b00);
      for (i = 0; i < 80 && !position_marker_first_out; i++) @(posedge sys_clk_in);
      repeat (10) @(posedge sys_clk_in);
      check(position_marker_first_out, 1'b1);
      check(step_position_out, 6'h00);
      rdr(OFS_STEP_CTRL);
      check(rd[15:0], 16'd7);
      // held at the marker the host may not write, so reset instead
      reset_in <= 1'b1;
      repeat (2) @(posedge sys_clk_in);
      reset_in <= 1'b0;
      wr(OFS_STEP_SETUP, 32'h80, 2'b00);
      wr(OFS_STEP_SETUP, 32'h580, 2'b00);
      repeat (10) @(posedge sys_clk_in);
      check(step_position_out, 6'h00);
      wr(OFS_STEP_SETUP, 32'h80, 2'b00);
      wr(OFS_STEP_SETUP, 32'h180, 2'b00);
      repeat (10) @(posedge sys_clk_in);
      check(step_position_out, 6'h08);
      check(step_full_duty_out, 1'b1);
      wr(OFS_STEP_CTRL, 32'd1, 2'b00);
      repeat (10) @(posedge sys_clk_in);
      check(step_position_out, 6'h18);
      wr(OFS_STEP_SETUP, 32'h80, 2'b00);
      wr(OFS_STEP_SETUP, 32'h580, 2'b00);
      wr(OFS_STEP_CTRL, 32'd1, 2'b00);
      repeat (10) @(posedge sys_clk_in);
      check(step_position_out, 6'h28);
      close_out();
   end
endmodule : motor_drive_command_decode_tb_top
